// >>> shared/spi_prot_pkg.sv
package spi_prot_pkg;
  localparam int CLK_PERIOD_NS = 50;
  // max_frame_time; no figure is fixed for it, plain default
  localparam int MAX_FRAME_NS = 100000;
  // longest time rounds down to whole cycles
  localparam int FRAME_MAX_CYC = MAX_FRAME_NS / CLK_PERIOD_NS;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CNT_SAT = 5'h1f;
  localparam logic [4:0] ADDR_DONE_BIT = 5'h06;
  localparam logic [4:0] LAST_TX_BIT = 5'h0e;
  localparam logic REPLY_CMD = 1'b1;
  localparam logic [5:0] ADDR_ERR_FLAGS = 6'h20;
  localparam logic [5:0] ADDR_PROT_KEY = 6'h21;
  localparam logic [5:0] ADDR_PROT_STAT = 6'h22;
  localparam logic [5:0] ADDR_PROT_REQ = 6'h23;
  localparam logic [5:0] ADDR_PROT_ACT = 6'h24;
  localparam logic [31:0] UNLOCK_KEYS = 32'hab_ef_56_12;
  localparam logic [31:0] LOCK_KEYS = 32'hdf_34_be_ca;
  localparam logic [3:0] KEY_LAST = 4'h7;
  localparam logic [7:0] PROT_CFG_RST = 8'h00;

  typedef struct packed {
    logic key_seq;
    logic dur;
    logic len;
    logic addr;
    logic par;
  } err_flags_t;

  typedef struct packed {
    logic cmd;
    logic [5:0] addr;
    logic [7:0] data;
    logic par;
  } frame_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DEAD = 3'b100
  } link_st_t;
endpackage : spi_prot_pkg

// >>> rtl/spi_prot_slave.sv
`timescale 1ns/10ps
module spi_prot_slave
  import spi_prot_pkg::*;
#(
  parameter int FRAME_MAX = FRAME_MAX_CYC
) (
  input wire logic i_clk, // 20 MHz system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_ce, // clock enable, freezes all state
  input wire logic i_sclk, // serial clock pin
  input wire logic i_cs_n, // chip select pin, active low
  input wire logic i_serial_data_in, // serial data pin
  output logic o_serial_data_out, // serial data out
  output logic o_serial_data_out_oe, // high while driving
  output logic o_serial_irq, // one-cycle error event
  output err_flags_t o_serial_error_flags, // sticky error flags
  output logic o_protection_state_flag, // 1 = request register writes blocked
  output logic [7:0] o_active_cfg // active protected setting
);
  localparam int TMO_W = $clog2(FRAME_MAX + 1);

  ////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [1:0] sclk_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] sdi_s_q;
  logic sclk_d_q;
  logic cs_d_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_s_q <= 2'h3;
      cs_s_q <= 2'h3;
      sdi_s_q <= 2'h0;
      sclk_d_q <= 1'b1;
      cs_d_q <= 1'b1;
    end else if (i_ce) begin
      sclk_s_q <= {sclk_s_q[0], i_sclk};
      cs_s_q <= {cs_s_q[0], i_cs_n};
      sdi_s_q <= {sdi_s_q[0], i_serial_data_in};
      sclk_d_q <= sclk_s_q[1];
      cs_d_q <= cs_s_q[1];
    end
  end

  logic sclk_fall;
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  logic sdi_now;
  assign sclk_fall = sclk_d_q & ~sclk_s_q[1];
  assign sclk_rise = ~sclk_d_q & sclk_s_q[1];
  assign cs_fall = cs_d_q & ~cs_s_q[1];
  assign cs_rise = ~cs_d_q & cs_s_q[1];
  assign sdi_now = sdi_s_q[1];

  ////////////////////////////////////////////////////////////
  // frame state and time-out
  link_st_t st_q;
  logic [TMO_W-1:0] tmo_q;
  logic tmo_hit;
  assign tmo_hit = (st_q == ST_SHIFT) && !cs_rise
    && (tmo_q == TMO_W'(FRAME_MAX - 1));
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= ST_IDLE;
      tmo_q <= '0;
    end else if (i_ce) begin
      case (st_q)
        ST_IDLE: begin
          tmo_q <= '0;
          if (cs_fall) begin
            st_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          tmo_q <= tmo_q + 1'b1;
          if (cs_rise) begin
            st_q <= ST_IDLE;
          end else if (tmo_hit) begin
            st_q <= ST_DEAD;
          end
        end
        ST_DEAD: begin
          if (cs_rise) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // receive path: sample on falling, shift on rising
  logic [4:0] cnt_q;
  logic [15:0] rx_q;
  logic smp_q;
  logic wr_q;
  logic in_frame;
  logic wr_now;
  frame_t fr;
  assign in_frame = (st_q == ST_SHIFT);
  assign fr = frame_t'(rx_q);
  // command bit is still on the pin during the first falling edge
  assign wr_now = (cnt_q == 5'h00) ? sdi_now : wr_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
      rx_q <= '0;
      smp_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (i_ce) begin
      if (cs_fall) begin
        cnt_q <= '0;
        wr_q <= 1'b0;
      end else if (in_frame && sclk_fall) begin
        smp_q <= sdi_now;
        wr_q <= wr_now;
      end else if (in_frame && sclk_rise) begin
        rx_q <= {rx_q[14:0], smp_q};
        if (cnt_q != CNT_SAT) begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // protection state and read data
  logic locked_q;
  logic [3:0] ukey_q;
  logic [3:0] lkey_q;
  logic [7:0] req_q;
  logic [7:0] act_q;
  err_flags_t flags_q;
  function automatic logic [7:0] key_at(input logic [31:0] k, input logic [3:0] p);
    case (p)
      4'h0: key_at = k[31:24];
      4'h1: key_at = k[23:16];
      4'h3: key_at = k[15:8];
      default: key_at = k[7:0];
    endcase
  endfunction : key_at
  function automatic logic addr_ok(input logic [5:0] a);
    addr_ok = (a == ADDR_ERR_FLAGS) || (a == ADDR_PROT_KEY)
      || (a == ADDR_PROT_STAT) || (a == ADDR_PROT_REQ)
      || (a == ADDR_PROT_ACT);
  endfunction : addr_ok
  logic [5:0] rd_addr;
  logic [7:0] rdata;
  assign rd_addr = {rx_q[4:0], sdi_now};
  always_comb begin
    case (rd_addr)
      ADDR_ERR_FLAGS: rdata = {3'h0, flags_q};
      ADDR_PROT_KEY: rdata = {lkey_q, ukey_q};
      ADDR_PROT_STAT: rdata = {7'h00, locked_q};
      ADDR_PROT_REQ: rdata = ~req_q;
      ADDR_PROT_ACT: rdata = ~act_q;
      default: rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////
  // transmit path
  logic [15:0] tx_q;
  logic [5:0] stat_q;
  logic rd_bad_q;
  logic rd_load;
  logic rd_bad;
  logic [5:0] stat_now;
  assign stat_now = {locked_q, flags_q};
  assign rd_load = in_frame && sclk_fall && !wr_now
    && (cnt_q == ADDR_DONE_BIT);
  assign rd_bad = !addr_ok(rd_addr);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_q <= '0;
      stat_q <= '0;
      rd_bad_q <= 1'b0;
      o_serial_data_out <= 1'b0;
    end else if (i_ce) begin
      if (cs_fall) begin
        tx_q <= {REPLY_CMD, stat_now, 9'h000};
        stat_q <= stat_now;
        rd_bad_q <= 1'b0;
        o_serial_data_out <= REPLY_CMD;
      end else if (rd_load) begin
        tx_q[14:7] <= rdata;
        // reply parity, spoiled on a bad address
        tx_q[6] <= ^{REPLY_CMD, stat_q, rdata} ^ rd_bad;
        rd_bad_q <= rd_bad;
        o_serial_data_out <= rdata[7];
      end else if (in_frame && sclk_fall && cnt_q <= LAST_TX_BIT) begin
        o_serial_data_out <= wr_now ? sdi_now : tx_q[14];
      end else if (in_frame && sclk_rise) begin
        tx_q <= {tx_q[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_serial_data_out_oe <= 1'b0;
    end else if (i_ce) begin
      if (cs_fall) begin
        o_serial_data_out_oe <= 1'b1;
      end else if (cs_rise || tmo_hit) begin
        o_serial_data_out_oe <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // end-of-frame checks once chip select is back high; the time-out flag is set while select is still low
  err_flags_t set_e;
  logic wr_ok;
  logic key_err;
  logic frame_end;
  assign frame_end = in_frame && cs_rise;
  // kept out of the flag process so the key check cannot feed back into it
  assign wr_ok = frame_end && (cnt_q == FRAME_BITS) && !(^rx_q) && fr.cmd
    && addr_ok(fr.addr);
  always_comb begin
    set_e = '0;
    if (frame_end) begin
      if (cnt_q != FRAME_BITS) begin
        set_e.len = 1'b1;
      end else if (^rx_q) begin
        set_e.par = 1'b1;
      end else if (fr.cmd) begin
        if (!addr_ok(fr.addr)) begin
          set_e.addr = 1'b1;
        end
      end else if (rd_bad_q) begin
        set_e.addr = 1'b1;
      end
    end
    set_e.dur = tmo_hit;
    set_e.key_seq = key_err;
  end

  ////////////////////////////////////////////////////////////
  // key sequences
  logic key_wr;
  logic u_match;
  logic l_match;
  assign key_wr = wr_ok && (fr.addr == ADDR_PROT_KEY);
  assign u_match = (lkey_q == 4'h0)
    && (fr.data == key_at(UNLOCK_KEYS, ukey_q));
  assign l_match = (ukey_q == 4'h0)
    && (fr.data == key_at(LOCK_KEYS, lkey_q));
  // any other accepted write in mid-sequence breaks it; reads and rejected writes do not
  assign key_err = (key_wr && !u_match && !l_match)
    || (wr_ok && !key_wr && (ukey_q != 4'h0 || lkey_q != 4'h0));
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      locked_q <= 1'b1;
      ukey_q <= 4'h0;
      lkey_q <= 4'h0;
      act_q <= PROT_CFG_RST;
    end else if (i_ce) begin
      if (key_err) begin
        ukey_q <= 4'h0;
        lkey_q <= 4'h0;
      end else if (key_wr && u_match) begin
        if (ukey_q == KEY_LAST) begin
          ukey_q <= 4'h0;
          locked_q <= 1'b0;
        end else begin
          ukey_q <= {ukey_q[2:0], 1'b1};
        end
      end else if (key_wr && l_match) begin
        if (lkey_q == KEY_LAST) begin
          lkey_q <= 4'h0;
          locked_q <= 1'b1;
          // applied the next cycle, well inside the allowed delay
          act_q <= req_q;
        end else begin
          lkey_q <= {lkey_q[2:0], 1'b1};
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_q <= PROT_CFG_RST;
    end else if (i_ce) begin
      if (wr_ok && fr.addr == ADDR_PROT_REQ && !locked_q) begin
        req_q <= fr.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // sticky flags, write one to clear; a new event beats the clear
  err_flags_t clr_e;
  assign clr_e = (wr_ok && fr.addr == ADDR_ERR_FLAGS)
    ? err_flags_t'(fr.data[4:0]) : '0;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_q <= '0;
      o_serial_irq <= 1'b0;
    end else if (i_ce) begin
      flags_q <= (flags_q & ~clr_e) | set_e;
      o_serial_irq <= |set_e;
    end
  end

  assign o_serial_error_flags = flags_q;
  assign o_protection_state_flag = locked_q;
  assign o_active_cfg = act_q;

endmodule : spi_prot_slave

// >>> verif/spi_prot_slave_monitor.sv
`timescale 1ns/10ps
module spi_prot_slave_monitor
  import spi_prot_pkg::*;
#(
  parameter int FRAME_MAX = FRAME_MAX_CYC
) (
  input wire logic i_clk, // clock
  input wire logic i_rstn, // reset
  input wire logic i_ce, // enable
  input wire logic i_sclk, // serial clock
  input wire logic i_cs_n, // select
  input wire logic i_serial_data_in, // data in
  input wire logic o_serial_data_out, // data out
  input wire logic o_serial_data_out_oe, // drive
  input wire logic o_serial_irq, // event
  input wire err_flags_t o_serial_error_flags, // flags
  input wire logic o_protection_state_flag, // locked
  input wire logic [7:0] o_active_cfg // active
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  int low_q;
  // select-low time; capped so it cannot wrap
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) low_q <= 0;
    else if (i_cs_n) low_q <= 0;
    else if (low_q < FRAME_MAX + 16) low_q <= low_q + 1;
  end
  ////////////////////////
  sequence s_sel;
    $fell(i_cs_n);
  endsequence
  sequence s_reply;
    o_serial_data_out_oe && o_serial_data_out;
  endsequence
  property p_reply_start;
    s_sel |-> ##[3:5] s_reply;
  endproperty
  a_reply_start: assert property (p_reply_start) else $error("reply start bit missing");
  property p_oe_idle;
    i_cs_n [*6] |-> !o_serial_data_out_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
  property p_sdo_fall;
    o_serial_data_out_oe && $past(o_serial_data_out_oe) && $changed(o_serial_data_out)
      |-> $past(i_sclk, 3) == 1'b0;
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("output changed off falling edge");
  property p_irq_end;
    o_serial_irq |-> ##[0:1] !o_serial_data_out_oe;
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("event inside a frame");
  property p_flags_irq;
    (o_serial_error_flags & ~$past(o_serial_error_flags)) != 5'h00 |-> o_serial_irq || $past(o_serial_irq);
  endproperty
  a_flags_irq: assert property (p_flags_irq) else $error("flag set without event");
  property p_lock_copy;
    $changed(o_active_cfg) |-> o_protection_state_flag && !$past(o_protection_state_flag, 2);
  endproperty
  a_lock_copy: assert property (p_lock_copy) else $error("active setting changed outside lock");
  property p_state_end;
    $changed(o_protection_state_flag) |-> i_cs_n && $past(i_cs_n, 3);
  endproperty
  a_state_end: assert property (p_state_end) else $error("protection changed mid frame");
  property p_timeout;
    low_q > FRAME_MAX + 6 |-> !o_serial_data_out_oe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("output kept past time-out");
endmodule : spi_prot_slave_monitor

bind spi_prot_slave spi_prot_slave_monitor #(.FRAME_MAX(FRAME_MAX)) u_spi_prot_slave_monitor (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
  .i_serial_data_in(i_serial_data_in), .o_serial_data_out(o_serial_data_out),
  .o_serial_data_out_oe(o_serial_data_out_oe), .o_serial_irq(o_serial_irq),
  .o_serial_error_flags(o_serial_error_flags), .o_protection_state_flag(o_protection_state_flag),
  .o_active_cfg(o_active_cfg)
);

// >>> verif/spi_master_model.sv
`timescale 1ns/10ps
module spi_master_model (
  input wire logic i_clk, // time base
  output logic o_sclk, // serial clock
  output logic o_cs_n, // select
  output logic o_ser_in, // data to device
  input wire logic i_ser_out, // device data
  input wire logic i_ser_oe // device drive
);
  // released line floats: stale level must not pass
  wire line = i_ser_oe ? i_ser_out : ~i_ser_out;
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_ser_in = 1'b0;
  end
  ////////////////////////
  task automatic xfer(input logic [15:0] f, input int n, input int hold, output logic [15:0] r);
    r = 16'h0000;
    @(posedge i_clk) begin
      o_cs_n <= 1'b0;
      o_ser_in <= f[15];
    end
    repeat (5) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      @(negedge i_clk) if (i < 16) r[15 - i] = line;
      @(posedge i_clk) o_sclk <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      o_ser_in <= (i < 15) ? f[14 - i] : 1'b0;
      repeat (3) @(posedge i_clk);
    end
    repeat (hold + 4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_ser_in <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask : xfer
endmodule : spi_master_model

// >>> verif/spi_prot_slave_test.sv
`timescale 1ns/10ps
module spi_prot_slave_test;
  import spi_prot_pkg::*;
  localparam int FMAX = 400;
  logic clk, rstn, sclk, cs_n, ser_in, ser_out, oe, irq, pflag;
  err_flags_t flags;
  logic [7:0] act;
  logic [15:0] rx;
  int n_fail, n_tests, n_irq;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
  spi_prot_slave #(.FRAME_MAX(FMAX)) u_spi_prot_slave (.i_clk(clk), .i_rstn(rstn), .i_ce(1'b1),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_data_in(ser_in), .o_serial_data_out(ser_out),
    .o_serial_data_out_oe(oe), .o_serial_irq(irq), .o_serial_error_flags(flags),
    .o_protection_state_flag(pflag), .o_active_cfg(act));
  spi_master_model u_spi_master_model (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_ser_in(ser_in),
    .i_ser_out(ser_out), .i_ser_oe(oe));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (irq === 1'b1) n_irq++;
  end
  ////////////////////////
  function automatic logic [15:0] fr(logic c, logic [5:0] a, logic [7:0] d);
    return {c, a, d, ^{c, a, d}};
  endfunction : fr
  task automatic xf(logic [15:0] f, int n = 16, int hold = 0);
    u_spi_master_model.xfer(f, n, hold, rx);
  endtask : xf
  task automatic wr(logic [5:0] a, logic [7:0] d);
    logic [15:0] f;
    f = fr(1'b1, a, d);
    xf(f);
    `CHK(rx, {1'b1, f[15:1]})
  endtask : wr
  task automatic rd(logic [5:0] a, logic [5:0] st, logic [7:0] d, logic bad = 1'b0, int n = 16);
    xf(fr(1'b0, a, 8'h00), n);
    `CHK(rx, {1'b1, st, d, (^{1'b1, st, d}) ^ bad})
  endtask : rd
  task automatic err(err_flags_t e);
    `CHK(flags, e)
    `CHK(n_irq, 1)
    n_irq = 0;
    wr(6'h20, 8'h1f);
  endtask : err
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  ////////////////////////
  initial begin
    rstn = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(flags, 5'h00)
    `CHK(pflag, 1'b1)
    `CHK(oe, 1'b0)
    rd(6'h22, 6'h20, 8'h01);
    wr(6'h23, 8'h5a);
    rd(6'h23, 6'h20, 8'hff);
    for (int i = 0; i < 4; i++) begin
      wr(6'h21, UNLOCK_KEYS[31 - 8 * i -: 8]);
      if (i == 0) rd(6'h21, 6'h20, 8'h01);
    end
    `CHK(pflag, 1'b0)
    wr(6'h23, 8'h5a);
    rd(6'h23, 6'h00, 8'ha5);
    for (int i = 0; i < 4; i++) wr(6'h21, LOCK_KEYS[31 - 8 * i -: 8]);
    `CHK(pflag, 1'b1)
    `CHK(act, 8'h5a)
    rd(6'h24, 6'h20, 8'ha5);
    wr(6'h21, 8'hab);
    wr(6'h21, 8'h00);
    err(5'h10);
    wr(6'h21, 8'hdf);
    wr(6'h23, 8'h00);
    err(5'h10);
    xf(fr(1'b1, 6'h23, 8'h11) ^ 16'h0001);
    err(5'h01);
    wr(6'h3f, 8'h00);
    err(5'h02);
    rd(6'h30, 6'h20, 8'h00, 1'b1);
    err(5'h02);
    xf(fr(1'b1, 6'h23, 8'h11), 15);
    err(5'h04);
    rd(6'h22, 6'h20, 8'h01, 1'b0, 17);
    err(5'h04);
    xf(fr(1'b0, 6'h22, 8'h00), 16, FMAX);
    err(5'h08);
    `CHK(act, 8'h5a)
    conclude();
  end
  initial begin
    #1000000;
    n_fail++;
    conclude();
  end
endmodule : spi_prot_slave_test
